// File: vrfpm_consts.svh
`ifndef VRFPM_CONSTS_SVH
`define VRFPM_CONSTS_SVH
// Register byte addresses
`define VRFPM_A_CTRL      12'h000
`define VRFPM_A_MODE      12'h004
`define VRFPM_A_QUAL      12'h008
`define VRFPM_A_STATUS    12'h00c
`define VRFPM_A_OUTSTATE  12'h010
`define VRFPM_A_CMD       12'h014
// Control bit positions
`define VRFPM_CTRL_EN     0
`define VRFPM_CTRL_OVRST  1
// Command bit positions (write one to act)
`define VRFPM_CMD_CLR     0
`define VRFPM_CMD_ENTOG   1
// Status bit positions
`define VRFPM_ST_OVA      0
`define VRFPM_ST_OVR      1
`define VRFPM_ST_RV       2
`define VRFPM_ST_OC       3
`define VRFPM_ST_UV       4
`define VRFPM_ST_OT       5
`define VRFPM_ST_CF       6
`define VRFPM_ST_CML      7
`define VRFPM_ST_NVM      8
`define VRFPM_ST_VIN      9
`define VRFPM_NST         10
// Mode field positions
`define VRFPM_M_OV        0
`define VRFPM_M_OC        2
`define VRFPM_M_UV        4
// Qualification defaults, cycles
`define VRFPM_QUAL_RST    8'h10
// Reset values: software enable on, every response latched
`define VRFPM_CTRL_RST    2'h1
`define VRFPM_MODE_RST    6'h15
// Times
`define VRFPM_CLK_MHZ     100
`define VRFPM_RESTART_US  12500
`define VRFPM_VALLEY_NS   150
`define VRFPM_RESTART_CYC (`VRFPM_RESTART_US * `VRFPM_CLK_MHZ)
`define VRFPM_VALLEY_CYC  ((`VRFPM_VALLEY_NS * `VRFPM_CLK_MHZ) / 1000)
`endif

// File: vrfpm_pkg.sv
`default_nettype none
package vrfpm_pkg;
   typedef enum logic [1:0] {VRFPM_NOACT, VRFPM_LATCH, VRFPM_RETRY, VRFPM_HICCUP} vrfpm_resp_t;
   typedef struct packed {
      logic ov_abs;
      logic ov_rel;
      logic rev;
      logic oc;
      logic uv;
      logic hot;
      logic cool;
      logic vin_ov;
      logic vin_low;
      logic vin_high;
   } vrfpm_sense_t;
   typedef struct packed {
      logic soft_start;
      logic soft_stop;
      logic decay;
      logic settled;
   } vrfpm_ramp_t;
   typedef struct packed {
      logic bad_len;
      logic bad_rw;
      logic bad_cmd;
   } vrfpm_comm_t;
endpackage
`default_nettype wire

// File: vrfpm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vrfpm_consts.svh"
module vrfpm_top #(
   parameter int NPH = 6,
   parameter int RESTART_CYC = `VRFPM_RESTART_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Sensing
   input wire vrfpm_pkg::vrfpm_sense_t sense_i,
   input wire vrfpm_pkg::vrfpm_ramp_t ramp_i,
   input wire vrfpm_pkg::vrfpm_comm_t comm_i,
   input wire logic en_pin_i,
   input wire logic init_done_i,
   input wire logic cfg_invalid_i,
   input wire logic [NPH-1:0] valley_oc_i,
   input wire logic [NPH-1:0] phase_req_i,
   // Phase outputs
   output logic [NPH-1:0] phase_on_o,
   output logic [NPH-1:0] phase_hiz_o,
   output logic forced_continuous_flag_o,
   output logic regulator_run_o,
   // Alarm pins (open drain, oe high drives low)
   output logic thermal_alarm_out_o,
   output logic thermal_alarm_out_oe_o,
   output logic catastrophic_fault_protect_o,
   output logic catastrophic_fault_protect_oe_o,
   output logic host_alert_out_o,
   output logic host_alert_out_oe_o
);
   import vrfpm_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [1:0] ctrl_ff;
   logic [5:0] mode_ff;
   logic [7:0] qual_ff;
   logic [`VRFPM_NST-1:0] status_ff;
   logic en_pin_ff;
   logic ov_latch_ff, rv_latch_ff, off_latch_ff, hot_ff, alert_ff, nvm_ff;
   logic [31:0] rst_cnt_ff;
   logic restart_wait_ff;
   logic [7:0] q_ova_ff, q_ovr_ff, q_oc_ff, q_uv_ff;
   logic [NPH-1:0] blk_ff;
   logic [7:0] blk_cnt_ff;

   logic wr, rd, cmd_wr, clr_cmd, en_cmd_tog, en_pin_tog, toggle, enabled;
   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && penable_i && !pwrite_i;
   assign cmd_wr = wr && (paddr_i == `VRFPM_A_CMD);
   assign clr_cmd = cmd_wr && pwdata_i[`VRFPM_CMD_CLR];
   assign en_cmd_tog = cmd_wr && pwdata_i[`VRFPM_CMD_ENTOG];
   assign en_pin_tog = en_pin_i != en_pin_ff;
   assign toggle = en_pin_tog || en_cmd_tog || sense_i.vin_low;
   assign enabled = en_pin_i && ctrl_ff[`VRFPM_CTRL_EN];

   function automatic vrfpm_resp_t mode_of(input logic [5:0] m, input int pos);
      return vrfpm_resp_t'(m[pos +: 2]);
   endfunction

   // ----------------------------------------
   // Qualification
   // ----------------------------------------
   logic ova_c, ovr_c, oc_c, uv_c, ova_t, ovr_t, oc_t, uv_t;
   assign ova_c = enabled && sense_i.ov_abs;
   assign ovr_c = enabled && sense_i.ov_rel && ramp_i.settled && !ramp_i.soft_start
                  && !ramp_i.soft_stop && !ramp_i.decay;
   assign oc_c = enabled && sense_i.oc && !ramp_i.soft_start;
   assign uv_c = enabled && sense_i.uv;

   function automatic logic [7:0] qstep(input logic c, input logic [7:0] q, input logic [7:0] lim);
      if (!c)
      begin
         return 8'h00;
      end
      return (q < lim) ? q + 8'h01 : q;
   endfunction

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q_ova_ff <= 8'h00;
         q_ovr_ff <= 8'h00;
         q_oc_ff <= 8'h00;
         q_uv_ff <= 8'h00;
      end
      else
      begin
         q_ova_ff <= qstep(ova_c, q_ova_ff, qual_ff);
         q_ovr_ff <= qstep(ovr_c, q_ovr_ff, qual_ff);
         q_oc_ff <= qstep(oc_c, q_oc_ff, qual_ff);
         q_uv_ff <= qstep(uv_c, q_uv_ff, qual_ff);
      end
   end
   assign ova_t = ova_c && (q_ova_ff == qual_ff);
   assign ovr_t = ovr_c && (q_ovr_ff == qual_ff);
   assign oc_t = oc_c && (q_oc_ff == qual_ff);
   assign uv_t = uv_c && (q_uv_ff == qual_ff);

   // ----------------------------------------
   // Protection latches
   // ----------------------------------------
   logic ov_act, rv_t, oc_act, uv_act, ovr_act;
   assign ovr_act = ovr_t && mode_of(mode_ff, `VRFPM_M_OV) != VRFPM_NOACT;
   assign ov_act = ova_t || ovr_act;
   assign rv_t = enabled && sense_i.rev;
   assign oc_act = oc_t && mode_of(mode_ff, `VRFPM_M_OC) != VRFPM_NOACT;
   assign uv_act = uv_t && mode_of(mode_ff, `VRFPM_M_UV) != VRFPM_NOACT;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ov_latch_ff <= 1'b0;
      end
      else if (ov_act)
      begin
         ov_latch_ff <= 1'b1;
      end
      else if (toggle || rv_t)
      begin
         ov_latch_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rv_latch_ff <= 1'b0;
      end
      else if (rv_t)
      begin
         rv_latch_ff <= 1'b1;
      end
      else if (toggle || ov_act)
      begin
         rv_latch_ff <= 1'b0;
      end
   end

   // Restartable shutdown from OC/UV; relative OV retry frees run but ov_latch_ff holds the phases until a toggle
   logic latch_req, retry_req, ov_retry;
   assign ov_retry = ovr_act && !ova_t && ctrl_ff[`VRFPM_CTRL_OVRST];
   assign latch_req = (oc_act && mode_of(mode_ff, `VRFPM_M_OC) == VRFPM_LATCH)
                      || (uv_act && mode_of(mode_ff, `VRFPM_M_UV) == VRFPM_LATCH);
   assign retry_req = (oc_act && mode_of(mode_ff, `VRFPM_M_OC) != VRFPM_LATCH)
                      || (uv_act && mode_of(mode_ff, `VRFPM_M_UV) != VRFPM_LATCH) || ov_retry;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         off_latch_ff <= 1'b0;
      end
      else if (latch_req)
      begin
         off_latch_ff <= 1'b1;
      end
      else if (toggle)
      begin
         off_latch_ff <= 1'b0;
      end
   end

   // Restart timer starts only once the fault has cleared
   logic fault_live;
   assign fault_live = sense_i.oc || sense_i.uv || sense_i.ov_rel;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         restart_wait_ff <= 1'b0;
         rst_cnt_ff <= 32'h0;
      end
      else if (retry_req)
      begin
         restart_wait_ff <= 1'b1;
         rst_cnt_ff <= 32'h0;
      end
      else if (restart_wait_ff)
      begin
         if (fault_live)
         begin
            rst_cnt_ff <= 32'h0;
         end
         else if (rst_cnt_ff >= 32'(RESTART_CYC - 1))
         begin
            restart_wait_ff <= 1'b0;
            if (ov_latch_ff && !ova_t)
            begin
               rst_cnt_ff <= 32'h0;
            end
         end
         else
         begin
            rst_cnt_ff <= rst_cnt_ff + 32'h1;
         end
      end
   end

   // Nonvolatile fault state holds until config valid
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         nvm_ff <= 1'b0;
      end
      else
      begin
         nvm_ff <= cfg_invalid_i;
      end
   end

   // ----------------------------------------
   // Phase drive
   // ----------------------------------------
   logic run;
   assign run = enabled && !off_latch_ff && !restart_wait_ff && !nvm_ff && sense_i.vin_high
                && !sense_i.vin_low;
   assign regulator_run_o = run;

   // Valley limit: every phase with valley_oc_i set is blocked, its request passed to the next phase after timeout
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         blk_cnt_ff <= 8'h00;
      end
      else if (|(phase_req_i & valley_oc_i) && blk_cnt_ff < 8'(`VRFPM_VALLEY_CYC))
      begin
         blk_cnt_ff <= blk_cnt_ff + 8'h01;
      end
      else if (!(|(phase_req_i & valley_oc_i)))
      begin
         blk_cnt_ff <= 8'h00;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPH; g++)
      begin : g_ph
         logic hand;
         assign hand = (blk_cnt_ff >= 8'(`VRFPM_VALLEY_CYC)) && phase_req_i[(g + NPH - 1) % NPH]
                       && valley_oc_i[(g + NPH - 1) % NPH] && !valley_oc_i[g];
         always_ff @(posedge clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
            begin
               phase_on_o[g] <= 1'b0;
               phase_hiz_o[g] <= 1'b1;
            end
            else if (rv_latch_ff || rv_t)
            begin
               phase_on_o[g] <= 1'b0;
               phase_hiz_o[g] <= 1'b1;
            end
            else if (ov_latch_ff || ov_act)
            begin
               phase_on_o[g] <= 1'b0;
               phase_hiz_o[g] <= 1'b0;
            end
            else
            begin
               phase_on_o[g] <= run && ((phase_req_i[g] && !valley_oc_i[g]) || hand);
               phase_hiz_o[g] <= !run;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         forced_continuous_flag_o <= 1'b0;
      end
      else
      begin
         forced_continuous_flag_o <= (ov_latch_ff || ov_act) && !(rv_latch_ff || rv_t);
      end
   end

   // ----------------------------------------
   // Alarm pins
   // ----------------------------------------
   // Thermal alarm only reports; it feeds nothing in the run path
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hot_ff <= 1'b0;
      end
      else if (sense_i.hot)
      begin
         hot_ff <= 1'b1;
      end
      else if (sense_i.cool)
      begin
         hot_ff <= 1'b0;
      end
   end
   assign thermal_alarm_out_o = 1'b0;
   assign thermal_alarm_out_oe_o = init_done_i && hot_ff;
   assign catastrophic_fault_protect_o = 1'b0;
   // Unqualified on purpose: the supply must be cut at once
   assign catastrophic_fault_protect_oe_o = sense_i.vin_ov || sense_i.ov_abs;
   assign host_alert_out_o = 1'b0;
   assign host_alert_out_oe_o = alert_ff;

   // ----------------------------------------
   // Sticky status and alert
   // ----------------------------------------
   logic [`VRFPM_NST-1:0] ev;
   always_comb
   begin
      ev = '0;
      ev[`VRFPM_ST_OVA] = ova_t;
      ev[`VRFPM_ST_OVR] = ovr_t;
      ev[`VRFPM_ST_RV] = rv_t;
      ev[`VRFPM_ST_OC] = oc_t;
      ev[`VRFPM_ST_UV] = uv_t;
      ev[`VRFPM_ST_OT] = hot_ff;
      ev[`VRFPM_ST_CF] = catastrophic_fault_protect_oe_o;
      ev[`VRFPM_ST_CML] = |comm_i;
      ev[`VRFPM_ST_NVM] = cfg_invalid_i;
      ev[`VRFPM_ST_VIN] = sense_i.vin_low;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         status_ff <= '0;
      end
      else if (clr_cmd || en_pin_tog || en_cmd_tog)
      begin
         status_ff <= ev;
      end
      else
      begin
         status_ff <= status_ff | ev;
      end
   end

   // Alert drops on clear unless comm_i is set that cycle; a fault still present re-raises it next cycle
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         alert_ff <= 1'b0;
      end
      else if (|comm_i)
      begin
         alert_ff <= 1'b1;
      end
      else if (clr_cmd)
      begin
         alert_ff <= 1'b0;
      end
      else if (|status_ff)
      begin
         alert_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // APB register file
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_ff <= `VRFPM_CTRL_RST;
         mode_ff <= `VRFPM_MODE_RST;
         qual_ff <= `VRFPM_QUAL_RST;
         en_pin_ff <= 1'b0;
      end
      else
      begin
         en_pin_ff <= en_pin_i;
         if (wr && paddr_i == `VRFPM_A_CTRL)
         begin
            ctrl_ff <= pwdata_i[1:0];
         end
         else if (wr && paddr_i == `VRFPM_A_MODE)
         begin
            mode_ff <= pwdata_i[5:0];
         end
         else if (wr && paddr_i == `VRFPM_A_QUAL)
         begin
            qual_ff <= (pwdata_i[7:0] == 8'h00) ? 8'h01 : pwdata_i[7:0];
         end
      end
   end

   logic hit;
   assign hit = (paddr_i == `VRFPM_A_CTRL) || (paddr_i == `VRFPM_A_MODE) || (paddr_i == `VRFPM_A_QUAL)
                || (paddr_i == `VRFPM_A_STATUS) || (paddr_i == `VRFPM_A_OUTSTATE)
                || (paddr_i == `VRFPM_A_CMD);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         prdata_o <= 32'h0;
      end
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         if (paddr_i == `VRFPM_A_CTRL)
         begin
            prdata_o <= {30'h0, ctrl_ff};
         end
         else if (paddr_i == `VRFPM_A_MODE)
         begin
            prdata_o <= {26'h0, mode_ff};
         end
         else if (paddr_i == `VRFPM_A_QUAL)
         begin
            prdata_o <= {24'h0, qual_ff};
         end
         else if (paddr_i == `VRFPM_A_STATUS)
         begin
            prdata_o <= {22'h0, status_ff};
         end
         else if (paddr_i == `VRFPM_A_OUTSTATE)
         begin
            prdata_o <= {25'h0, run, ov_latch_ff, rv_latch_ff, off_latch_ff, restart_wait_ff, nvm_ff,
                         alert_ff};
         end
         else
         begin
            prdata_o <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: vrfpm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vrfpm_checker #(
   parameter int NPH = 6
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [11:0] paddr_i,
   input wire logic pslverr_o,
   // Sensing
   input wire vrfpm_pkg::vrfpm_sense_t sense_i,
   input wire vrfpm_pkg::vrfpm_comm_t comm_i,
   input wire logic init_done_i,
   input wire logic [NPH-1:0] valley_oc_i,
   // Watched outputs
   input wire logic [NPH-1:0] phase_on_o,
   input wire logic [NPH-1:0] phase_hiz_o,
   input wire logic forced_continuous_flag_o,
   input wire logic thermal_alarm_out_oe_o,
   input wire logic catastrophic_fault_protect_oe_o,
   input wire logic host_alert_out_oe_o
);
   import vrfpm_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // ---------------------------------------------
   // Alarm, phase and bus relations
   // ---------------------------------------------
   sequence s_hot_armed;
      sense_i.hot && init_done_i ##1 init_done_i;
   endsequence
   sequence s_hot_held;
      thermal_alarm_out_oe_o && !sense_i.cool ##1 init_done_i;
   endsequence
   AST_THERM_SET: assert property (s_hot_armed |-> thermal_alarm_out_oe_o)
      else $error("thermal alarm not raised");
   AST_THERM_HOLD: assert property (s_hot_held |-> thermal_alarm_out_oe_o)
      else $error("thermal alarm released early");
   AST_THERM_INIT: assert property (!init_done_i |-> !thermal_alarm_out_oe_o)
      else $error("thermal alarm driven before init");
   AST_CFP: assert property (sense_i.vin_ov || sense_i.ov_abs |-> catastrophic_fault_protect_oe_o)
      else $error("catastrophic pin not pulled");
   AST_REV_HIZ: assert property (sense_i.rev |=> phase_hiz_o == {NPH{1'b1}})
      else $error("phases not high impedance");
   AST_OV_CROWBAR: assert property ($rose(forced_continuous_flag_o) |-> phase_on_o == '0 && phase_hiz_o == '0)
      else $error("crowbar state wrong");
   AST_COMM_ALERT: assert property (comm_i != '0 |=> host_alert_out_oe_o)
      else $error("alert not raised on bad transfer");
   AST_VALLEY: assert property (($past(valley_oc_i) & phase_on_o & ~$past(phase_on_o)) == '0)
      else $error("blocked phase turned on");
   AST_SLVERR: assert property (psel_i && penable_i && paddr_i > 12'h014 |-> pslverr_o)
      else $error("unmapped access not refused");
endmodule
bind vrfpm_top vrfpm_checker #(.NPH(NPH)) u_vrfpm_chk (
   .clk_i, .arst_n_i, .psel_i, .penable_i, .paddr_i, .pslverr_o, .sense_i, .comm_i,
   .init_done_i, .valley_oc_i, .phase_on_o, .phase_hiz_o, .forced_continuous_flag_o,
   .thermal_alarm_out_oe_o, .catastrophic_fault_protect_oe_o, .host_alert_out_oe_o
);
`default_nettype wire

// File: vrfpm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module vrfpm_pin_model (
   // Controller open-drain drives
   input wire logic therm_d_i,
   input wire logic therm_oe_i,
   input wire logic cf_d_i,
   input wire logic cf_oe_i,
   input wire logic alert_d_i,
   input wire logic alert_oe_i,
   // Board-level lines
   output logic therm_line_o,
   output logic cf_line_o,
   output logic alert_line_o
);
   // ---------------------------------------------
   // Pull-ups: a released line reads high
   // ---------------------------------------------
   assign therm_line_o = therm_oe_i ? therm_d_i : 1'b1;
   assign cf_line_o = cf_oe_i ? cf_d_i : 1'b1;
   assign alert_line_o = alert_oe_i ? alert_d_i : 1'b1;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vrfpm_pkg::*;
   logic clk, arst_n, psel, penable, pwrite, serr, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   vrfpm_sense_t sense;
   vrfpm_ramp_t ramp;
   vrfpm_comm_t comm;
   logic en_pin, init_done, cfg_inv, forced_continuous_flag, run;
   logic [5:0] valley, preq, ph_on, ph_hiz;
   logic therm_d, therm_oe, cf_d, cf_oe, alert_d, alert_oe, therm_ln, cf_ln, alert_ln;
   int fails = 0;
   int checks_done = 0;
   // Short restart wait keeps the run brief
   vrfpm_top #(.NPH(6), .RESTART_CYC(50)) DUT (
      .clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .sense_i(sense), .ramp_i(ramp), .comm_i(comm), .en_pin_i(en_pin), .init_done_i(init_done),
      .cfg_invalid_i(cfg_inv), .valley_oc_i(valley), .phase_req_i(preq), .phase_on_o(ph_on),
      .phase_hiz_o(ph_hiz), .forced_continuous_flag_o(forced_continuous_flag), .regulator_run_o(run),
      .thermal_alarm_out_o(therm_d), .thermal_alarm_out_oe_o(therm_oe),
      .catastrophic_fault_protect_o(cf_d), .catastrophic_fault_protect_oe_o(cf_oe),
      .host_alert_out_o(alert_d), .host_alert_out_oe_o(alert_oe)
   );
   vrfpm_pin_model u_pins (
      .therm_d_i(therm_d), .therm_oe_i(therm_oe), .cf_d_i(cf_d), .cf_oe_i(cf_oe),
      .alert_d_i(alert_d), .alert_oe_i(alert_oe), .therm_line_o(therm_ln),
      .cf_line_o(cf_ln), .alert_line_o(alert_ln)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------
   task automatic test_done();
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      chk(32'(pready), 32'h1);
      if (pready !== 1'b1)
         test_done();
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   initial
   begin
      #500us;
      fails++;
      $display("FAIL %0t run timed out", $time);
      test_done();
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial
   begin
      int k;
      logic [11:0] ra [4];
      logic [31:0] rv [4];
      ra = '{12'h000, 12'h004, 12'h008, 12'h00c};
      rv = '{32'h1, 32'h15, 32'h10, 32'h0};
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      // Input supply above turn-on, output settled
      sense = 10'h001;
      ramp = 4'b0001;
      comm = '0;
      {en_pin, init_done, cfg_inv, valley, preq} = {3'b100, 6'h00, 6'h3f};
      cyc(5);
      arst_n <= 1'b1;
      cyc(1);
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b0, 12'h040, 32'h0);
      chk(32'(serr), 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h008, 32'h2);
      sense.hot <= 1'b1;
      cyc(3);
      chk(32'(therm_ln), 32'h1);
      init_done <= 1'b1;
      cyc(3);
      chk(32'({therm_ln, run}), 32'h1);
      sense.hot <= 1'b0;
      cyc(5);
      chk(32'(therm_ln), 32'h0);
      sense.cool <= 1'b1;
      cyc(3);
      chk(32'(therm_ln), 32'h1);
      apb(1'b1, 12'h014, 32'h1);
      ramp <= 4'b1000;
      sense.ov_rel <= 1'b1;
      cyc(10);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd & 32'h2, 32'h0);
      ramp <= 4'b0001;
      cyc(8);
      chk(32'({forced_continuous_flag, ph_on, ph_hiz}), 32'h1000);
      sense.ov_rel <= 1'b0;
      cyc(20);
      apb(1'b0, 12'h00c, 32'h0);
      chk(32'({forced_continuous_flag, rd[1]}), 32'h3);
      en_pin <= 1'b0;
      cyc(2);
      en_pin <= 1'b1;
      cyc(3);
      apb(1'b0, 12'h00c, 32'h0);
      chk(32'({forced_continuous_flag, rd}), 32'h0);
      sense.ov_abs <= 1'b1;
      cyc(1);
      chk(32'(cf_ln), 32'h0);
      cyc(7);
      chk(32'({forced_continuous_flag, ph_hiz}), 32'h40);
      sense.ov_abs <= 1'b0;
      sense.rev <= 1'b1;
      cyc(1);
      sense.rev <= 1'b0;
      cyc(2);
      chk(32'({forced_continuous_flag, ph_hiz}), 32'h3f);
      sense.vin_ov <= 1'b1;
      cyc(1);
      chk(32'(cf_ln), 32'h0);
      sense.vin_ov <= 1'b0;
      sense.ov_abs <= 1'b1;
      cyc(8);
      chk(32'({forced_continuous_flag, ph_hiz}), 32'h40);
      sense.ov_abs <= 1'b0;
      apb(1'b1, 12'h014, 32'h2);
      cyc(2);
      apb(1'b0, 12'h00c, 32'h0);
      chk(32'({forced_continuous_flag, rd}), 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         comm <= 3'b100 >> i;
         cyc(1);
         comm <= 3'b000;
         cyc(2);
         chk(32'(alert_ln), 32'h0);
         apb(1'b0, 12'h00c, 32'h0);
         chk(rd, 32'h80);
         apb(1'b1, 12'h014, 32'h1);
         cyc(2);
         chk(32'(alert_ln), 32'h1);
      end
      cfg_inv <= 1'b1;
      cyc(3);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd & 32'h2, 32'h2);
      apb(1'b1, 12'h014, 32'h1);
      cyc(2);
      chk(32'(alert_ln), 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h100);
      cfg_inv <= 1'b0;
      cyc(2);
      apb(1'b1, 12'h014, 32'h1);
      cyc(2);
      chk(32'(alert_ln), 32'h1);
      ramp <= 4'b1000;
      sense.oc <= 1'b1;
      cyc(10);
      ramp <= 4'b0001;
      sense.oc <= 1'b0;
      cyc(1);
      // Two short bursts must not add up
      repeat (2)
      begin
         sense.oc <= 1'b1;
         cyc(2);
         sense.oc <= 1'b0;
         cyc(1);
      end
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd & 32'h8, 32'h0);
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, 12'h004, 32'h11 | (m << 2));
         sense.oc <= 1'b1;
         cyc(8);
         chk(32'(run), 32'(m == 0));
         sense.oc <= 1'b0;
         cyc(40);
         chk(32'(run), 32'(m == 0));
         cyc(30);
         chk(32'(run), 32'(m != 1));
         apb(1'b1, 12'h014, 32'h2);
         k = 0;
         while (run !== 1'b1 && k < 100)
         begin
            cyc(1);
            k++;
         end
         chk(32'(run), 32'h1);
      end
      sense.uv <= 1'b1;
      cyc(8);
      chk(32'({run, ph_on}), 32'h0);
      sense.uv <= 1'b0;
      apb(1'b1, 12'h014, 32'h2);
      cyc(5);
      valley <= 6'h01;
      preq <= 6'h01;
      cyc(20);
      chk(32'(ph_on[1:0]), 32'h2);
      valley <= 6'h00;
      preq <= 6'h3f;
      sense.vin_low <= 1'b1;
      cyc(2);
      chk(32'(run), 32'h0);
      sense.vin_low <= 1'b0;
      cyc(3);
      chk(32'(run), 32'h1);
      test_done();
   end
endmodule
`default_nettype wire
